// File: logic/gde_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module gde_fifo #(
    parameter int W  = 2,
    parameter int D  = 32,
    parameter int CW = 6
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Fill side
    input  wire logic          in_valid,
    output logic               in_ready,
    input  wire logic [W-1:0]  in_data,
    // Drain side
    output logic               out_valid,
    input  wire logic          out_ready,
    output logic [W-1:0]       out_data,
    // Fill level
    output logic [CW-1:0]      level
);
    localparam int PW = $clog2(D);

    logic [W-1:0]  mem_q [D];     // Storage array
    logic [PW-1:0] wr_q;          // Write pointer
    logic [PW-1:0] rd_q;          // Read pointer
    logic [CW-1:0] cnt_q;         // Words held
    logic          push;
    logic          pop;

    // Honest flags straight from the count
    assign in_ready  = (cnt_q != CW'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Storage has no reset; only the pointers and count matter
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= PW'(wr_q + 1'b1);
            end
            if (pop) begin
                rd_q <= PW'(rd_q + 1'b1);
            end
            if (push && !pop) begin
                cnt_q <= CW'(cnt_q + 1'b1);
            end else if (pop && !push) begin
                cnt_q <= CW'(cnt_q - 1'b1);
            end
        end
    end
endmodule

// File: logic/gde_gpio_cell.sv
// GPIO cell with single- and dual-edge paths, bypass feed and Avalon-MM control
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
module gde_gpio_cell (
    // Clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    // Avalon-MM slave
    input  wire logic [gde_pkg::BUS_AW-1:0]  avs_address,
    input  wire logic                        avs_read,
    input  wire logic                        avs_write,
    input  wire logic [gde_pkg::BUS_DW-1:0]  avs_writedata,
    input  wire logic [gde_pkg::BUS_BE-1:0]  avs_byteenable,
    output logic [gde_pkg::BUS_DW-1:0]       avs_readdata,
    output logic                             avs_waitrequest,
    // Core side data
    input  wire logic [1:0]                  core_out,
    input  wire logic                        core_oe,
    output logic [1:0]                       core_in,
    // Pad
    input  wire logic                        pad_i,
    output logic                             pad_o,
    output logic                             pad_oe,
    // Bypass feed destinations
    output logic                             global_clock_net,
    output logic                             global_control_net,
    output logic                             synth_reference_input,
    output logic                             camera_link_reference_input
);
    import gde_pkg::*;

    // Map a software mode code onto the one-hot mode
    function automatic gde_mode_t decode_mode(input logic [1:0] code);
        gde_mode_t m;
        m = GDE_IN;
        if (code == MC_OUT) begin
            m = GDE_OUT;
        end else if (code == MC_BIDIR) begin
            m = GDE_BIDIR;
        end else if (code == MC_CLKOUT) begin
            m = GDE_CLKOUT;
        end
        return m;
    endfunction

    // Merge write data into a word under byte enables
    function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < BUS_BE; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Configuration and bus state
    logic [31:0]        ctrl_q;        // Control register
    logic               ack_q;         // Bus answer phase
    logic [31:0]        rdata_q;       // Registered read data
    logic [31:0]        rmux;          // Read data selection
    logic               ovf_q;         // Sticky missed-sample flag
    logic               stall_q;       // Capture held off by a full FIFO
    // Decoded configuration
    gde_mode_t          mode;
    logic               dual_w;        // Dual-edge in force
    logic               resync_w;      // Resync sub-mode in force
    logic               in_en;         // Input path enabled
    logic               out_en;        // Output path enabled
    logic               bypass_sel;    // Bypass feed selected
    logic [1:0]         route;         // Bypass destination
    // Input registers
    logic               in_pos_q;      // Rising-edge sample
    logic               in_neg_q;      // Falling-edge sample
    logic               in_pos_rs_q;   // Rising sample, realigned
    logic               in_neg_rs_q;   // Falling sample, half period later
    // Output and enable registers
    logic               out_pos_q;     // Rising-edge launch
    logic               out_neg_q;     // Falling-edge launch
    logic               out_lo_rs_q;   // Second bit caught on rising edge
    logic               oe_pos_q;
    logic               oe_neg_q;
    logic               out_val;
    logic               oe_val;
    // Pad level synchroniser for status
    logic               pad_s1_q;
    logic               pad_s2_q;
    logic               pad_s3_q;
    logic               pad_lvl_q;
    // FIFO hookup
    logic               push_valid;
    logic               push_ready;
    logic               pop_valid;
    logic               pop_ready;
    logic [FIFO_W-1:0]  pop_data;
    logic [FIFO_CW-1:0] fifo_lvl;
    // Bus decode
    logic               req;
    logic               take_wr;
    logic               miss;

    // Configuration decode
    always_comb begin
        mode       = decode_mode(ctrl_q[CF_MODE_HI:CF_MODE_LO]);
        dual_w     = ctrl_q[CF_DUAL] && !ctrl_q[CF_DIFF];
        resync_w   = dual_w && ctrl_q[CF_RESYNC];
        in_en      = (mode == GDE_IN) || (mode == GDE_BIDIR);
        out_en     = (mode == GDE_OUT) || (mode == GDE_BIDIR);
        bypass_sel = (mode == GDE_IN) && !ctrl_q[CF_IN_REG] && !dual_w;
        route      = ctrl_q[CF_ROUTE_HI:CF_ROUTE_LO];
    end

    // Rising-edge input registers and resync stage
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            in_pos_q    <= 1'b0;
            in_pos_rs_q <= 1'b0;
            in_neg_rs_q <= 1'b0;
        end else begin
            in_pos_q    <= pad_i;
            in_pos_rs_q <= in_pos_q;
            in_neg_rs_q <= in_neg_q;
        end
    end

    // Falling-edge input register
    always_ff @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            in_neg_q <= 1'b0;
        end else begin
            in_neg_q <= pad_i;
        end
    end

    // Data toward the core; zero while the input path is off
    always_comb begin
        core_in = '0;
        if (in_en) begin
            if (resync_w) begin
                core_in = {in_neg_rs_q, in_pos_rs_q};
            end else if (dual_w) begin
                core_in = {in_neg_q, in_pos_q};
            end else if (ctrl_q[CF_IN_REG]) begin
                core_in[0] = ctrl_q[CF_IN_NEG] ? in_neg_q : in_pos_q;
            end else begin
                core_in[0] = pad_i;
            end
        end
    end

    // Rising-edge output and enable registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_pos_q   <= 1'b0;
            out_lo_rs_q <= 1'b0;
            oe_pos_q    <= 1'b0;
        end else begin
            out_pos_q   <= core_out[0];
            out_lo_rs_q <= core_out[1];
            oe_pos_q    <= core_oe;
        end
    end

    // Falling-edge output and enable registers
    always_ff @(negedge ref_clk or posedge rst) begin
        if (rst) begin
            out_neg_q <= 1'b0;
            oe_neg_q  <= 1'b0;
        end else begin
            // Resync takes bit1 from rising stage
            if (resync_w) begin
                out_neg_q <= out_lo_rs_q;
            end else if (dual_w) begin
                out_neg_q <= core_out[1];
            end else begin
                out_neg_q <= core_out[0];
            end
            oe_neg_q  <= core_oe;
        end
    end

    // Output value and drive enable selection
    always_comb begin
        if (dual_w) begin
            out_val = ref_clk ? out_pos_q : out_neg_q;
        end else if (ctrl_q[CF_OUT_REG]) begin
            out_val = ctrl_q[CF_OUT_NEG] ? out_neg_q : out_pos_q;
        end else begin
            out_val = core_out[0];
        end
        out_val = out_val ^ ctrl_q[CF_INVERT];
        if (ctrl_q[CF_OE_REG]) begin
            oe_val = ctrl_q[CF_OE_NEG] ? oe_neg_q : oe_pos_q;
        end else begin
            oe_val = core_oe;
        end
    end

    // Pad drive per mode; the clock glitches safely only at mode change
    always_comb begin
        pad_o  = 1'b0;
        pad_oe = 1'b0;
        case (mode)
            GDE_IN: begin
                pad_oe = 1'b0;
            end
            GDE_OUT: begin
                pad_o  = out_val;
                pad_oe = 1'b1;
            end
            GDE_BIDIR: begin
                pad_o  = out_val;
                pad_oe = oe_val;
            end
            GDE_CLKOUT: begin
                pad_o  = ref_clk;
                pad_oe = 1'b1;
            end
            default: begin
                pad_oe = 1'b0;
            end
        endcase
    end

    // Bypass feed: straight wire from the pad, no register anywhere
    always_comb begin
        global_clock_net            = bypass_sel && (route == RT_GLOBAL_CLOCK_NET) && pad_i;
        global_control_net          = bypass_sel && (route == RT_GLOBAL_CONTROL_NET) && pad_i;
        synth_reference_input       = bypass_sel && (route == RT_SYNTH) && pad_i;
        camera_link_reference_input = bypass_sel && (route == RT_CAMERA) && pad_i;
    end

    // Three-stage synchroniser; level accepted once stages two and three agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pad_s1_q  <= 1'b0;
            pad_s2_q  <= 1'b0;
            pad_s3_q  <= 1'b0;
            pad_lvl_q <= 1'b0;
        end else begin
            pad_s1_q <= pad_i;
            pad_s2_q <= pad_s1_q;
            pad_s3_q <= pad_s2_q;
            if (pad_s2_q == pad_s3_q) begin
                pad_lvl_q <= pad_s3_q;
            end
        end
    end

    // Capture core-side samples into the FIFO; a full FIFO stalls capture
    assign push_valid = ctrl_q[CF_CAPTURE] && in_en;
    assign miss       = push_valid && !push_ready;

    // Sample buffer between the cell and software
    gde_fifo #(
        .W  (FIFO_W),
        .D  (FIFO_D),
        .CW (FIFO_CW)
    ) u_fifo (
        .clk       (ref_clk),
        .rst       (rst),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (core_in),
        .out_valid (pop_valid),
        .out_ready (pop_ready),
        .out_data  (pop_data),
        .level     (fifo_lvl)
    );

    // Bus handshake: one wait cycle, then the answer edge
    assign req             = avs_read || avs_write;
    assign avs_waitrequest = req && !ack_q;
    assign avs_readdata    = rdata_q;
    assign take_wr         = avs_write && ack_q;
    assign pop_ready       = avs_read && ack_q && (avs_address == OFS_DATA);

    // Answer phase flag
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req && !ack_q;
        end
    end

    // Read selection; unmapped addresses read zero
    always_comb begin
        rmux = '0;
        if (avs_address == OFS_CTRL) begin
            rmux = ctrl_q;
        end else if (avs_address == OFS_STATUS) begin
            rmux[ST_PAD]                = pad_lvl_q;
            rmux[ST_OVF]                = ovf_q;
            rmux[ST_STALL]              = stall_q;
            rmux[ST_LVL_HI:ST_LVL_LO]   = fifo_lvl;
        end else if (avs_address == OFS_DATA) begin
            rmux[DT_VALID]              = pop_valid;
            rmux[FIFO_W-1:0]            = pop_data;
        end
    end

    // Read data held from the wait cycle through the answer edge
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (avs_read && !ack_q) begin
            rdata_q <= rmux;
        end
    end

    // Control register write
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
        end else if (take_wr && (avs_address == OFS_CTRL)) begin
            ctrl_q <= merge_be(ctrl_q, avs_writedata, avs_byteenable) & CTRL_MASK;
        end
    end

    // Missed-sample flag: a new miss wins over a same-cycle clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ovf_q   <= 1'b0;
            stall_q <= 1'b0;
        end else begin
            stall_q <= miss;
            if (miss) begin
                ovf_q <= 1'b1;
            end else if (take_wr && (avs_address == OFS_STATUS) && avs_byteenable[0]
                         && avs_writedata[ST_OVF]) begin
                ovf_q <= 1'b0;
            end
        end
    end

    // Checks on the cell's own behaviour
    sequence s_wait;
        req && !ack_q;
    endsequence
    sequence s_done;
        !avs_waitrequest ##1 !ack_q;
    endsequence
    property p_bus_answer;
        @(posedge ref_clk) disable iff (rst) s_wait |=> s_done;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    property p_in_off;
        @(posedge ref_clk) disable iff (rst) !in_en |-> (core_in == '0);
    endproperty
    a_in_off: assert property (p_in_off) else $error("input path live outside input modes");

    property p_dual_rise;
        @(posedge ref_clk) disable iff (rst)
            (in_en && dual_w && !resync_w && $stable(ctrl_q)) |-> (core_in[0] == $past(pad_i));
    endproperty
    a_dual_rise: assert property (p_dual_rise) else $error("rising sample wrong");

    property p_resync;
        @(posedge ref_clk) disable iff (rst)
            (in_en && resync_w && $stable(ctrl_q)) |-> (core_in[1] == $past(in_neg_q));
    endproperty
    a_resync: assert property (p_resync) else $error("resync falling bit misaligned");

    property p_out_reg;
        @(posedge ref_clk) disable iff (rst)
            (mode == GDE_OUT && ctrl_q[CF_OUT_REG] && !ctrl_q[CF_OUT_NEG] && !dual_w && $stable(ctrl_q))
            |-> (pad_o == ($past(core_out[0]) ^ ctrl_q[CF_INVERT]));
    endproperty
    a_out_reg: assert property (p_out_reg) else $error("registered output wrong");

    property p_oe_in;
        @(posedge ref_clk) disable iff (rst) (mode == GDE_IN) |-> !pad_oe;
    endproperty
    a_oe_in: assert property (p_oe_in) else $error("pad driven in input mode");

    property p_oe_out;
        @(posedge ref_clk) disable iff (rst) (out_en && mode != GDE_BIDIR) |-> pad_oe;
    endproperty
    a_oe_out: assert property (p_oe_out) else $error("pad not driven in output mode");

    property p_oe_reg;
        @(posedge ref_clk) disable iff (rst)
            (mode == GDE_BIDIR && ctrl_q[CF_OE_REG] && !ctrl_q[CF_OE_NEG] && $stable(ctrl_q))
            |-> (pad_oe == $past(core_oe));
    endproperty
    a_oe_reg: assert property (p_oe_reg) else $error("registered drive enable wrong");

    property p_bypass;
        @(posedge ref_clk) disable iff (rst)
            !bypass_sel |-> !(global_clock_net || global_control_net || synth_reference_input
                              || camera_link_reference_input);
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass live with register option");

    property p_diff;
        @(posedge ref_clk) disable iff (rst) ctrl_q[CF_DIFF] |-> (core_in[1] == 1'b0);
    endproperty
    a_diff: assert property (p_diff) else $error("dual-edge on differential pin");

    property p_ovf;
        @(posedge ref_clk) disable iff (rst) miss |=> (ovf_q && stall_q);
    endproperty
    a_ovf: assert property (p_ovf) else $error("missed sample not flagged");
endmodule

// File: logic/gde_pkg.sv
// Constants and types shared by the dual-edge GPIO cell and its testbench; the cell sizes its sample FIFO from them
package gde_pkg;
    // Avalon-MM geometry and byte offsets
    localparam int          BUS_AW      = 4;
    localparam int          BUS_DW      = 32;
    localparam int          BUS_BE      = 4;
    localparam logic [3:0]  OFS_CTRL    = 4'h0;
    localparam logic [3:0]  OFS_STATUS  = 4'h4;
    localparam logic [3:0]  OFS_DATA    = 4'h8;
    // Reset value and writable mask of the control register
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK   = 32'h0000_7fff;
    // Control fields
    localparam int          CF_MODE_LO  = 0;
    localparam int          CF_MODE_HI  = 1;
    localparam int          CF_IN_REG   = 2;
    localparam int          CF_IN_NEG   = 3;
    localparam int          CF_OUT_REG  = 4;
    localparam int          CF_OUT_NEG  = 5;
    localparam int          CF_OE_REG   = 6;
    localparam int          CF_OE_NEG   = 7;
    localparam int          CF_INVERT   = 8;
    localparam int          CF_DUAL     = 9;
    localparam int          CF_RESYNC   = 10;
    localparam int          CF_DIFF     = 11;
    localparam int          CF_CAPTURE  = 12;
    localparam int          CF_ROUTE_LO = 13;
    localparam int          CF_ROUTE_HI = 14;
    // Status fields
    localparam int          ST_PAD      = 0;
    localparam int          ST_OVF      = 1;
    localparam int          ST_STALL    = 2;
    localparam int          ST_LVL_LO   = 8;
    localparam int          ST_LVL_HI   = 13;
    // Data register: valid flag position
    localparam int          DT_VALID    = 31;
    // Sample FIFO shape
    localparam int          FIFO_W      = 2;
    localparam int          FIFO_D      = 32;
    localparam int          FIFO_CW     = 6;
    // Mode codes as written by software
    localparam logic [1:0]  MC_IN       = 2'h0;
    localparam logic [1:0]  MC_OUT      = 2'h1;
    localparam logic [1:0]  MC_BIDIR    = 2'h2;
    localparam logic [1:0]  MC_CLKOUT   = 2'h3;
    // Bypass feed routing codes
    localparam logic [1:0]  RT_GLOBAL_CLOCK_NET     = 2'h0;
    localparam logic [1:0]  RT_GLOBAL_CONTROL_NET    = 2'h1;
    localparam logic [1:0]  RT_SYNTH    = 2'h2;
    localparam logic [1:0]  RT_CAMERA   = 2'h3;
    // Cell operating modes, one-hot
    typedef enum logic [3:0] {
        GDE_IN     = 4'b0001,
        GDE_OUT    = 4'b0010,
        GDE_BIDIR  = 4'b0100,
        GDE_CLKOUT = 4'b1000
    } gde_mode_t;
endpackage

// File: tb/gde_gpio_cell_tb_top.sv
// Register-level tests of the GPIO cell
`timescale 1ns/1ps
module gde_gpio_cell_tb_top;
    import gde_pkg::*;
    logic ref_clk = 0, rst = 1, rd = 0, wr = 0, oe = 0, lvl = 0, ddr_on = 0;
    logic ext, ddr_lvl;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rdt, q;
    logic [1:0] cout = 2'h0, cin;
    logic wt, pi, po, poe, gck, gct, syn, cam;
    int bad_count = 0, comparisons = 0;
    always #25 ref_clk = ~ref_clk;
    // Outside level: steady, or toggling on both edges so each edge register sees its own level
    always @(ref_clk) ddr_lvl <= ref_clk;
    always_comb ext = ddr_on ? ddr_lvl : lvl;
    gde_pad_model pad (.pad_o(po), .pad_oe(poe), .ext_val(ext), .pad_i(pi));
    gde_gpio_cell dut (.ref_clk(ref_clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdt), .avs_waitrequest(wt),
        .core_out(cout), .core_oe(oe), .core_in(cin), .pad_i(pi), .pad_o(po), .pad_oe(poe),
        .global_clock_net(gck), .global_control_net(gct), .synth_reference_input(syn),
        .camera_link_reference_input(cam));
    task close_out;
        if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %0t seen %h want %h", $time, s, e);
        end
    endtask
    // One bus access; held until waitrequest is seen low at an edge
    task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge ref_clk); while (wt !== 1'b0);
        q = rdt;
        wr <= 0;
        rd <= 0;
    endtask
    // Look a quarter period after a rising edge, where both edge registers are settled
    task cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #12;
    endtask
    initial begin
        #(50 * 3000);
        bad_count++;
        close_out();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst <= 0;
        @(posedge ref_clk);
        acc(0, OFS_CTRL, 0); chk(q, CTRL_RST);
        acc(0, 4'hc, 0); chk(q, 0);
        acc(1, OFS_CTRL, 32'hffffffff); acc(0, OFS_CTRL, 0); chk(q, CTRL_MASK);
        for (int r = 0; r < 4; r++) begin
            acc(1, OFS_CTRL, r << 13); lvl <= 1; cyc(1);
            chk({gck, gct, syn, cam, cin[0], poe}, {4'b1000 >> r, 2'b10});
            @(posedge ref_clk); lvl <= 0;
        end
        acc(1, OFS_CTRL, 32'h4); lvl <= 1; #12 chk({cin[0], gck}, 0);
        cyc(1); chk(cin[0], 1);
        acc(1, OFS_CTRL, 32'hc); lvl <= 0; @(negedge ref_clk); #12 chk(cin[0], 0);
        acc(1, OFS_CTRL, 32'h204); ddr_on <= 1; cyc(3); chk(cin, 2'b10);
        acc(1, OFS_CTRL, 32'ha04); cyc(3); chk(cin, 2'b00);
        acc(1, OFS_CTRL, 32'h604); ddr_on <= 0; lvl <= 1; cyc(1); chk(cin, 2'b10);
        cyc(1); chk(cin, 2'b11);
        acc(1, OFS_CTRL, 32'h111); cout <= 2'b01; cyc(1); chk({po, poe, cin}, 4'b0100);
        acc(1, OFS_CTRL, 32'h31); cout <= 2'b00; @(negedge ref_clk); #12 chk(po, 0);
        acc(1, OFS_CTRL, 32'h211); cout <= 2'b01; cyc(1); chk(po, 1);
        @(negedge ref_clk); #12 chk(po, 0);
        acc(1, OFS_CTRL, 32'h611); cout <= 2'b10; @(negedge ref_clk); #12 chk(po, 0);
        @(negedge ref_clk); #12 chk(po, 1);
        acc(1, OFS_CTRL, 32'h2); cyc(1); chk({poe, cin[0]}, 2'b01);
        @(posedge ref_clk); oe <= 1; cout <= 2'b00; #12 chk({poe, po, cin[0]}, 3'b100);
        acc(1, OFS_CTRL, 32'h42); oe <= 0; #12 chk(poe, 1); cyc(1); chk(poe, 0);
        acc(1, OFS_CTRL, 32'h3); cyc(1); chk(po, 1);
        @(negedge ref_clk); #12 chk({po, poe}, 2'b01);
        acc(1, OFS_CTRL, 32'h1000); cyc(40);
        acc(0, OFS_STATUS, 0); chk(q[2:1], 2'b11);
        acc(1, OFS_CTRL, 0); acc(0, OFS_STATUS, 0);
        chk({q[13:8], q[1]}, {6'd32, 1'b1});
        for (int i = 0; i < 32; i++) begin
            acc(0, OFS_DATA, 0); chk({q[31], q[0]}, 2'b11);
        end
        acc(0, OFS_DATA, 0); chk(q[31], 0);
        acc(1, OFS_STATUS, 32'h2); acc(0, OFS_STATUS, 0); chk(q[13:0], 14'h1);
        close_out();
    end
endmodule

// File: tb/gde_pad_model.sv
// Behavioural model of the circuit on the far side of the pad
`timescale 1ns/1ps
module gde_pad_model (
    // Cell side of the pad
    input  wire logic pad_o,
    input  wire logic pad_oe,
    // Level forced by the outside world
    input  wire logic ext_val,
    output logic      pad_i
);
    // enable decides
    // The cell wins while it drives, otherwise the outside level shows
    always_comb pad_i = pad_oe ? pad_o : ext_val;
endmodule
